// [src/ims_regs.svh]
`ifndef IMS_REGS_SVH
`define IMS_REGS_SVH
// Notes on behaviour
// - Fixed-register type: 19/20 clocks internal fetch, 21+w/22+w with external fetch.
// - General type memory-to-register: 30, 29 or 31+w clocks; up to 33+2w.
// - Output-port type with ring: longer count when ring counter is zero; plain 37.
// - Counts start after instruction end and priority identification, which add time.
// - Internal fetch figures only when internal fetch select is 1.
// - Buffers in 0FE00H-0FEFFH use internal RAM timing; other internal RAM uses w=0.
// - Register-transfer types may add up to 15 further wait clocks.
// - Output-port type takes one clock more when a timer 1 compare wait occurs.
// - Transfer on each request; vectored interrupt only after programmed count completes.
// - Vectored interrupt saves PC and status word; a serviced transfer skips that.
// - Seventeen sources may request service; at most fifteen enabled at once.
// - Timer 1 matches: all types; edges 3-5 and wide timer: general only.
// - Fixed-register type binds each source to one fixed register.
// - Fixed-register type moves exactly one byte per request in the selected direction.
// - Fixed-register type buffers lie only within 0FE00H-0FEFFH.
// - Service ignores the global enable; only the mask blocks it.
// - Each service decrements the counter; zero raises vector, else flag clears.
// - General type moves one byte between a chosen register and 0000H-FEFFH.
// - Output-port type writes port and timer 1 compare; timer 1 sources only.
`define IMS_NSRC 17
`define IMS_MAX_ACTIVE 5'h0f
`define IMS_IDENT_CLKS 2'h3
`define IMS_OFF_CTRL 8'h00
`define IMS_OFF_MASK 8'h04
`define IMS_OFF_FLAGS 8'h08
`define IMS_OFF_STATUS 8'h0c
`define IMS_OFF_MODE 8'h40
`define IMS_OFF_CHAN 8'h88
`define IMS_CTRL_RESET 32'h0000_0001
`define IMS_MASK_RESET 17'h1_ffff
`define IMS_TYPE_A 2'h0
`define IMS_TYPE_B 2'h1
`define IMS_TYPE_C 2'h2
`define IMS_IRAM_PAGE 8'hfe
`define IMS_ROM_LIMIT 16'h4000
`define IMS_PERI_LO 16'hfc80
`define IMS_PERI_HI 16'hfdff
`define IMS_MEM_TOP 16'hfeff
`define IMS_A_M2S 8'h13
`define IMS_B_ROM 8'h1e
`define IMS_B_RAM 8'h1d
`define IMS_B_EXT 8'h1f
`define IMS_B_S2M_RAM 8'h1f
`define IMS_B_S2M_EXT 8'h21
`define IMS_C_ROM 8'h25
`define IMS_C_RAM 8'h23
`define IMS_C_EXT 8'h27
`define IMS_C_ADD 8'h04
`define IMS_C_RING 8'h05
`define IMS_EXT_FETCH 8'h02
`endif

// [src/ims_pkg.sv]
package ims_pkg;
   typedef enum logic [1:0] {IMS_IDLE, IMS_SERVE} ims_state_e;
   typedef enum logic [1:0] {IMS_RGN_ROM, IMS_RGN_IRAM, IMS_RGN_OTHER, IMS_RGN_EXT} ims_rgn_e;
   typedef enum logic [3:0] {
      IMS_SFR_NONE, IMS_SFR_T1CMP_A, IMS_SFR_T1CMP_B, IMS_SFR_T2CMP_A, IMS_SFR_T2CMP_B,
      IMS_SFR_T2CMP_C, IMS_SFR_T3CMP, IMS_SFR_T2COUNT, IMS_SFR_CONV, IMS_SFR_URX,
      IMS_SFR_UTX, IMS_SFR_SYNC
   } ims_sfr_e;
   typedef struct packed {
      logic [1:0] typ;
      logic to_mem;
      logic ring;
      logic add;
      logic en;
      logic [7:0] sfr_addr;
   } ims_mode_s;
   typedef struct packed {
      logic valid;
      logic [4:0] src;
      logic [1:0] typ;
      logic to_mem;
      ims_sfr_e sfr;
      logic [7:0] sfr_addr;
      logic [15:0] mem_addr;
      logic port_too;
      logic add;
      logic last;
   } ims_xfer_s;
endpackage

// [src/ims_engine.sv]
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`include "ims_regs.svh"
module ims_engine (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic ce_i,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic [16:0] req_i,
   input wire logic insn_end_i,
   input wire logic hold_insn_i,
   input wire logic global_irq_enable_i,
   input wire logic vec_ack_i,
   input wire logic [4:0] vec_ack_src_i,
   output logic [16:0] vec_req_o,
   output logic busy_o,
   output ims_pkg::ims_xfer_s xfer_o
);
   import ims_pkg::*;

   ////////////////////////////////////////////////////////////////////////////////
   // Functions

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] sel);
      logic [31:0] r;
      r = old;
      for (int b = 0; b < 4; b++) begin
         if (sel[b]) begin
            r[b*8 +: 8] = nw[b*8 +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic type_ok(input logic [4:0] s, input logic [1:0] t);
      logic r;
      r = 1'b0;
      case (t)
         `IMS_TYPE_A: r = !(s inside {5'd3, 5'd4, 5'd5, 5'd6, 5'd7});
         `IMS_TYPE_B: r = 1'b1;
         `IMS_TYPE_C: r = (s == 5'd8) || (s == 5'd9);
         default: r = 1'b0;
      endcase
      return r;
   endfunction

   function automatic ims_sfr_e sfr_of(input logic [4:0] s);
      ims_sfr_e r;
      r = IMS_SFR_NONE;
      case (s)
         5'd0: r = IMS_SFR_T1CMP_B;
         5'd1: r = IMS_SFR_T2CMP_C;
         5'd2: r = IMS_SFR_T2COUNT;
         5'd8: r = IMS_SFR_T1CMP_A;
         5'd9: r = IMS_SFR_T1CMP_B;
         5'd10: r = IMS_SFR_T2CMP_A;
         5'd11: r = IMS_SFR_T2CMP_B;
         5'd12: r = IMS_SFR_T3CMP;
         5'd13: r = IMS_SFR_CONV;
         5'd14: r = IMS_SFR_URX;
         5'd15: r = IMS_SFR_UTX;
         5'd16: r = IMS_SFR_SYNC;
         default: r = IMS_SFR_NONE;
      endcase
      return r;
   endfunction

   function automatic ims_rgn_e rgn_of(input logic [15:0] a);
      ims_rgn_e r;
      r = IMS_RGN_EXT;
      if (a[15:8] == `IMS_IRAM_PAGE) begin
         r = IMS_RGN_IRAM;
      end else if (a >= `IMS_PERI_LO && a <= `IMS_PERI_HI) begin
         r = IMS_RGN_OTHER;
      end else if (a < `IMS_ROM_LIMIT) begin
         r = IMS_RGN_ROM;
      end
      return r;
   endfunction

   // Service length in clocks for one channel
   function automatic logic [7:0] svc_cycles(input ims_mode_s m, input ims_rgn_e g, input logic ring_zero,
                                              input logic [31:0] c);
      logic [7:0] n;
      logic [7:0] w;
      logic [7:0] mw;
      n = 8'h00;
      w = {4'h0, c[7:4]};
      mw = (g == IMS_RGN_OTHER) ? 8'h00 : w;
      case (m.typ)
         `IMS_TYPE_A: n = `IMS_A_M2S + {7'h00, m.to_mem};
         `IMS_TYPE_B: begin
            if (!m.to_mem) begin
               n = (g == IMS_RGN_ROM) ? `IMS_B_ROM : (g == IMS_RGN_IRAM) ? `IMS_B_RAM : `IMS_B_EXT + mw;
            end else begin
               n = (g == IMS_RGN_IRAM) ? `IMS_B_S2M_RAM : `IMS_B_S2M_EXT + mw;
            end
         end
         `IMS_TYPE_C: begin
            n = (g == IMS_RGN_ROM) ? `IMS_C_ROM : (g == IMS_RGN_IRAM) ? `IMS_C_RAM : `IMS_C_EXT + mw + mw;
            n = n + (m.add ? `IMS_C_ADD : 8'h00);
            n = n + (m.ring ? `IMS_C_RING : 8'h00) + ((m.ring && ring_zero) ? `IMS_C_RING : 8'h00);
         end
         default: n = 8'h00;
      endcase
      n = n + (c[0] ? 8'h00 : `IMS_EXT_FETCH + w);
      n = n + ((m.typ == `IMS_TYPE_C) ? {7'h00, c[12]} : {4'h0, c[11:8]});
      return n;
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Registers

   logic [31:0] ctrl;
   logic [16:0] mask;
   logic [16:0] flags;
   ims_mode_s mode [`IMS_NSRC];
   logic [7:0] count [`IMS_NSRC];
   logic [15:0] ptr [`IMS_NSRC];
   logic [1:0] age [`IMS_NSRC];
   ims_state_e state;
   logic [7:0] cnt;
   logic [7:0] len;
   logic [4:0] cur;
   logic [4:0] en_count;
   logic [16:0] eligible;
   logic [16:0] serviceable;
   logic [4:0] pick;
   logic pick_ok;
   logic accept;
   logic finish;
   logic [7:0] next_len;
   logic [7:0] left;
   logic wr;

   assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && ce_i;

   always_comb begin
      en_count = 5'h00;
      for (int i = 0; i < `IMS_NSRC; i++) begin
         en_count = en_count + {4'h0, mode[i].en};
         serviceable[i] = mode[i].en && type_ok(5'(i), mode[i].typ) && (count[i] != 8'h00);
         eligible[i] = flags[i] && !mask[i] && serviceable[i] && (age[i] == `IMS_IDENT_CLKS);
      end
   end

   always_comb begin
      pick = 5'h00;
      pick_ok = 1'b0;
      for (int i = `IMS_NSRC - 1; i >= 0; i--) begin
         if (eligible[i]) begin
            pick = 5'(i);
            pick_ok = 1'b1;
         end
      end
   end

   assign accept = ce_i && state == IMS_IDLE && pick_ok && insn_end_i && !hold_insn_i;
   assign finish = ce_i && state == IMS_SERVE && cnt == 8'h01;
   assign next_len = svc_cycles(mode[pick], rgn_of(ptr[pick]), ctrl[23:16] == 8'h00, ctrl);
   assign left = count[cur] - 8'h01;

   // Serviced sources never reach the vector path; the CPU pushes PC and status on vec_ack_i
   assign vec_req_o = flags & ~mask & ~serviceable & {17{global_irq_enable_i}};
   assign busy_o = state == IMS_SERVE;

   ////////////////////////////////////////////////////////////////////////////////
   // Bus slave

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else if (ce_i) begin
         wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
         wb_dat_o <= 32'h0000_0000;
         if (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i) begin
            if (wb_adr_i == `IMS_OFF_CTRL) begin
               wb_dat_o <= ctrl;
            end else if (wb_adr_i == `IMS_OFF_MASK) begin
               wb_dat_o <= {15'h0000, mask};
            end else if (wb_adr_i == `IMS_OFF_FLAGS) begin
               wb_dat_o <= {15'h0000, flags};
            end else if (wb_adr_i == `IMS_OFF_STATUS) begin
               wb_dat_o <= {11'h000, en_count, cnt, 2'h0, cur, busy_o};
            end else begin
               for (int i = 0; i < `IMS_NSRC; i++) begin
                  if (wb_adr_i == `IMS_OFF_MODE + 8'(i * 4)) begin
                     wb_dat_o <= {16'h0000, mode[i].sfr_addr, 2'h0, mode[i].en, mode[i].add, mode[i].ring,
                                  mode[i].to_mem, mode[i].typ};
                  end
                  if (wb_adr_i == `IMS_OFF_CHAN + 8'(i * 4)) begin
                     wb_dat_o <= {ptr[i], 8'h00, count[i]};
                  end
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ctrl <= `IMS_CTRL_RESET;
         mask <= `IMS_MASK_RESET;
      end else if (ce_i) begin
         if (wr && wb_adr_i == `IMS_OFF_CTRL) begin
            ctrl <= merge(ctrl, wb_dat_i, wb_sel_i);
         end else if (finish && mode[cur].typ == `IMS_TYPE_C && mode[cur].ring) begin
            ctrl[23:16] <= (ctrl[23:16] == 8'h00) ? ctrl[31:24] : ctrl[23:16] - 8'h01;
         end
         if (wr && wb_adr_i == `IMS_OFF_MASK) begin
            mask <= {wb_sel_i[2] ? wb_dat_i[16] : mask[16], wb_sel_i[1] ? wb_dat_i[15:8] : mask[15:8],
                     wb_sel_i[0] ? wb_dat_i[7:0] : mask[7:0]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Channels, flags and identification delay

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         for (int i = 0; i < `IMS_NSRC; i++) begin
            mode[i] <= '0;
            count[i] <= 8'h00;
            ptr[i] <= 16'h0000;
         end
      end else if (ce_i) begin
         for (int i = 0; i < `IMS_NSRC; i++) begin
            if (wr && wb_adr_i == `IMS_OFF_MODE + 8'(i * 4)) begin
               if (wb_sel_i[0]) begin
                  {mode[i].add, mode[i].ring, mode[i].to_mem, mode[i].typ} <= wb_dat_i[4:0];
                  mode[i].en <= wb_dat_i[5] && (mode[i].en || en_count < `IMS_MAX_ACTIVE);
               end
               mode[i].sfr_addr <= wb_sel_i[1] ? wb_dat_i[15:8] : mode[i].sfr_addr;
            end
            if (wr && wb_adr_i == `IMS_OFF_CHAN + 8'(i * 4)) begin
               count[i] <= wb_sel_i[0] ? wb_dat_i[7:0] : count[i];
               ptr[i] <= {wb_sel_i[3] ? wb_dat_i[31:24] : ptr[i][15:8], wb_sel_i[2] ? wb_dat_i[23:16] : ptr[i][7:0]};
            end else if (finish && cur == 5'(i)) begin
               count[i] <= left;
               ptr[i] <= (mode[i].typ == `IMS_TYPE_A) ? {`IMS_IRAM_PAGE, ptr[i][7:0] + 8'h01}
                                                     : ptr[i] + 16'h0001;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         flags <= 17'h0_0000;
         for (int i = 0; i < `IMS_NSRC; i++) begin
            age[i] <= 2'h0;
         end
      end else if (ce_i) begin
         for (int i = 0; i < `IMS_NSRC; i++) begin
            if (req_i[i]) begin
               flags[i] <= 1'b1;
            end else if ((wr && wb_adr_i == `IMS_OFF_FLAGS && wb_sel_i[i / 8] && wb_dat_i[i])
                         || (finish && cur == 5'(i) && left != 8'h00)
                         || (vec_ack_i && vec_ack_src_i == 5'(i))) begin
               flags[i] <= 1'b0;
            end
            if (!flags[i] || (finish && cur == 5'(i))) begin
               age[i] <= 2'h0;
            end else if (age[i] != `IMS_IDENT_CLKS) begin
               age[i] <= age[i] + 2'h1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Service sequencer

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state <= IMS_IDLE;
         cnt <= 8'h00;
         len <= 8'h00;
         cur <= 5'h00;
      end else if (ce_i) begin
         case (state)
            IMS_IDLE: begin
               if (accept) begin
                  state <= IMS_SERVE;
                  cur <= pick;
                  len <= next_len;
                  cnt <= next_len;
               end
            end
            IMS_SERVE: begin
               cnt <= cnt - 8'h01;
               if (cnt == 8'h01) begin
                  state <= IMS_IDLE;
               end
            end
            default: state <= IMS_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         xfer_o <= '0;
      end else if (ce_i) begin
         xfer_o.valid <= finish;
         if (finish) begin
            xfer_o.src <= cur;
            xfer_o.typ <= mode[cur].typ;
            xfer_o.to_mem <= mode[cur].to_mem && mode[cur].typ != `IMS_TYPE_C;
            xfer_o.sfr <= (mode[cur].typ == `IMS_TYPE_A) ? sfr_of(cur) : IMS_SFR_NONE;
            xfer_o.sfr_addr <= mode[cur].sfr_addr;
            xfer_o.mem_addr <= (mode[cur].typ == `IMS_TYPE_A) ? {`IMS_IRAM_PAGE, ptr[cur][7:0]}
                             : (ptr[cur] > `IMS_MEM_TOP ? `IMS_MEM_TOP : ptr[cur]);
            xfer_o.port_too <= mode[cur].typ == `IMS_TYPE_C;
            xfer_o.add <= mode[cur].typ == `IMS_TYPE_C && mode[cur].add;
            xfer_o.last <= left == 8'h00;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks

   logic [7:0] elapsed;
   always_ff @(posedge clk_i) begin
      if (rst_i || accept) begin
         elapsed <= 8'h00;
      end else if (ce_i && state == IMS_SERVE) begin
         elapsed <= elapsed + 8'h01;
      end
   end

   AST_A_MEM2SFR: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && mode[pick].typ == `IMS_TYPE_A && !mode[pick].to_mem && ctrl[0] && ctrl[11:8] == 4'h0
      |-> next_len == 8'd19) else $error("type A internal fetch length wrong");
   AST_A_EXTFETCH: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && mode[pick].typ == `IMS_TYPE_A && !mode[pick].to_mem && !ctrl[0] && ctrl[11:8] == 4'h0
      |-> next_len == 8'h15 + {4'h0, ctrl[7:4]}) else $error("type A external fetch length wrong");
   AST_B_IRAM: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && mode[pick].typ == `IMS_TYPE_B && !mode[pick].to_mem && ctrl[0] && ctrl[11:8] == 4'h0
      && ptr[pick][15:8] == `IMS_IRAM_PAGE |-> next_len == 8'd29) else $error("type B length wrong");
   AST_C_RINGZERO: assert property (@(posedge clk_i) disable iff (rst_i)
      accept && mode[pick].typ == `IMS_TYPE_C && mode[pick].ring && !mode[pick].add && ctrl[0] && !ctrl[12]
      && ptr[pick] < `IMS_ROM_LIMIT && ctrl[23:16] == 8'h00 |-> next_len == 8'd47) else $error("ring length wrong");
   AST_SVC_LEN: assert property (@(posedge clk_i) disable iff (rst_i || !ce_i)
      finish |-> elapsed + 8'h01 == len) else $error("service length differs from computed");
   AST_A_PAGE: assert property (@(posedge clk_i) disable iff (rst_i)
      xfer_o.valid && xfer_o.typ == `IMS_TYPE_A |-> xfer_o.mem_addr[15:8] == `IMS_IRAM_PAGE)
      else $error("type A buffer outside page");
   AST_BOUNDARY: assert property (@(posedge clk_i) disable iff (rst_i)
      ce_i && state == IMS_IDLE ##1 state == IMS_SERVE |-> $past(insn_end_i) && !$past(hold_insn_i))
      else $error("service started off boundary");
   AST_LAST_KEEPS: assert property (@(posedge clk_i) disable iff (rst_i)
      xfer_o.valid && xfer_o.last |-> flags[xfer_o.src]) else $error("flag lost on last transfer");
   AST_NO_VEC: assert property (@(posedge clk_i) disable iff (rst_i)
      xfer_o.valid && !xfer_o.last |-> !vec_req_o[xfer_o.src]) else $error("serviced request vectored");
   AST_MAX_ACTIVE: assert property (@(posedge clk_i) disable iff (rst_i)
      en_count <= `IMS_MAX_ACTIVE) else $error("too many channels enabled");

   COV_A: cover property (@(posedge clk_i) xfer_o.valid && xfer_o.typ == `IMS_TYPE_A);
   COV_C_RING: cover property (@(posedge clk_i) finish && mode[cur].ring && ctrl[23:16] == 8'h00);
   COV_VEC: cover property (@(posedge clk_i) xfer_o.valid && xfer_o.last ##1 vec_req_o != 17'h0_0000);
endmodule

// [verif/ims_src_model.sv]
`timescale 1ns/100ps
module ims_src_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic fire_i,
   input wire logic [4:0] fire_idx_i,
   output logic [16:0] req_o
);
   // One-clock request pulse on the chosen source, as a peripheral raises its flag
   always_ff @(posedge clk_i) begin
      if (rst_i || !fire_i) begin
         req_o <= 17'h0_0000;
      end else begin
         req_o <= 17'h0_0001 << fire_idx_i;
      end
   end
endmodule

// [verif/tb_interrupt_driven_transfer_service.sv]
`timescale 1ns/100ps
`include "ims_regs.svh"
module tb_interrupt_driven_transfer_service;
   import ims_pkg::*;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [31:0] wdat = 32'h0000_0000;
   logic [31:0] rdat;
   logic [31:0] rd;
   logic insn_end = 1'b0;
   logic hold = 1'b0;
   logic ie = 1'b0;
   logic vack = 1'b0;
   logic fire = 1'b0;
   logic [4:0] fidx = 5'h00;
   logic [16:0] req;
   logic [16:0] vreq;
   logic ack;
   logic busy;
   ims_xfer_s xfer;
   ims_xfer_s xf;
   int num_errors = 0;
   int check_count = 0;
   int n;
   logic [31:0] t_ctrl [11] = '{32'h0000_0001, 32'h0000_0001, 32'h0000_0020, 32'h0000_0f01, 32'h0000_0001,
      32'h0000_0001, 32'h0000_0031, 32'h0000_0001, 32'h0001_0001, 32'h0000_0001, 32'h0000_1001};
   logic [4:0] t_src [11] = '{5'h00, 5'h0e, 5'h0d, 5'h0a, 5'h03, 5'h03, 5'h03, 5'h09, 5'h09, 5'h09, 5'h09};
   logic [31:0] t_mode [11] = '{32'h0000_0020, 32'h0000_0024, 32'h0000_0020, 32'h0000_0020, 32'h0000_5521,
      32'h0000_5521, 32'h0000_5521, 32'h0000_0022, 32'h0000_002a, 32'h0000_002a, 32'h0000_0022};
   logic [31:0] t_chan [11] = '{32'hfe10_0002, 32'hfe20_0009, 32'hfe30_0009, 32'hfe40_0009, 32'h1000_0009,
      32'hfe20_0009, 32'hfd00_0009, 32'h1000_0009, 32'h1000_0009, 32'h1000_0009, 32'h1000_0009};
   int t_n [11] = '{19, 20, 23, 34, 30, 29, 31, 37, 42, 47, 38};
   ims_sfr_e t_sfr [11] = '{IMS_SFR_T1CMP_B, IMS_SFR_URX, IMS_SFR_CONV, IMS_SFR_T2CMP_A, IMS_SFR_NONE,
      IMS_SFR_NONE, IMS_SFR_NONE, IMS_SFR_NONE, IMS_SFR_NONE, IMS_SFR_NONE, IMS_SFR_NONE};

   always #4 clk_i = ~clk_i;

   ims_src_model src_u (.clk_i(clk_i), .rst_i(rst_i), .fire_i(fire), .fire_idx_i(fidx), .req_o(req));

   ims_engine dut_u (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
      .req_i(req), .insn_end_i(insn_end), .hold_insn_i(hold), .global_irq_enable_i(ie),
      .vec_ack_i(vack), .vec_ack_src_i(5'h00), .vec_req_o(vreq), .busy_o(busy), .xfer_o(xfer));

   ////////////////////////////////////////////////////////////////////////
   task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task finish_test;
      $display("checks %0d errors %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // Classic single cycle, held until ack is sampled high
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
      end while (ack !== 1'b1);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task pulse(input logic h);
      @(posedge clk_i);
      insn_end <= 1'b1;
      hold <= h;
      @(posedge clk_i);
      insn_end <= 1'b0;
      hold <= 1'b0;
   endtask

   // Request, then enough clocks for priority identification
   task fire_src(input logic [4:0] s);
      @(posedge clk_i);
      fire <= 1'b1;
      fidx <= s;
      @(posedge clk_i);
      fire <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask

   // Clocks from the accepting boundary to the transfer pulse
   task serve(output int cnt);
      pulse(1'b0);
      cnt = 0;
      do begin
         @(posedge clk_i);
         cnt++;
      end while (xfer.valid !== 1'b1 && cnt < 200);
      xf = xfer;
      cnt = cnt - 1;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (20000) @(posedge clk_i);
      num_errors++;
      finish_test();
   end

   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      chk("busy at reset", busy, 32'h0000_0000);
      wb(1'b0, `IMS_OFF_CTRL, 32'h0000_0000);
      chk("ctrl reset", rd, `IMS_CTRL_RESET);
      wb(1'b0, `IMS_OFF_MASK, 32'h0000_0000);
      chk("mask reset", rd, {15'h0000, `IMS_MASK_RESET});
      wb(1'b0, 8'h30, 32'h0000_0000);
      chk("unmapped read", rd, 32'h0000_0000);
      wb(1'b1, `IMS_OFF_MASK, 32'h0000_0000);
      // Boundary after a holding instruction is skipped
      wb(1'b1, `IMS_OFF_MODE + 8'h40, 32'h0000_0024);
      wb(1'b1, `IMS_OFF_CHAN + 8'h40, 32'hfe50_0009);
      fire_src(5'h10);
      pulse(1'b1);
      @(posedge clk_i);
      chk("busy after held boundary", busy, 32'h0000_0000);
      serve(n);
      chk("deferred service clocks", n, 32'd20);
      chk("sync register", xf.sfr, IMS_SFR_SYNC);
      chk("to memory", xf.to_mem, 32'h0000_0001);
      // Timing table across types, fetch, buffer area and waits, global enable off
      for (int i = 0; i < 11; i++) begin
         wb(1'b1, `IMS_OFF_CTRL, t_ctrl[i]);
         wb(1'b1, `IMS_OFF_MODE + {1'b0, t_src[i], 2'b00}, t_mode[i]);
         wb(1'b1, `IMS_OFF_CHAN + {1'b0, t_src[i], 2'b00}, t_chan[i]);
         fire_src(t_src[i]);
         serve(n);
         chk("service clocks", n, t_n[i]);
         chk("fixed register", xf.sfr, t_sfr[i]);
         chk("buffer address", xf.mem_addr, t_chan[i][31:16]);
         chk("direction", xf.to_mem, t_mode[i][2]);
         chk("port output", xf.port_too, t_mode[i][1]);
         chk("register address", xf.sfr_addr, t_mode[i][15:8]);
         chk("source", xf.src, t_src[i]);
      end
      // Final count raises the vectored request
      ie <= 1'b1;
      wb(1'b1, `IMS_OFF_CTRL, 32'h0000_0001);
      fire_src(5'h00);
      serve(n);
      chk("last transfer", xf.last, 32'h0000_0001);
      chk("next buffer byte", xf.mem_addr, 32'h0000_fe11);
      @(posedge clk_i);
      chk("vector raised", vreq[0], 32'h0000_0001);
      vack <= 1'b1;
      @(posedge clk_i);
      vack <= 1'b0;
      @(posedge clk_i);
      chk("vector taken", vreq[0], 32'h0000_0000);
      // Fixed-register type is not allowed on edge input 3
      wb(1'b1, `IMS_OFF_MODE + 8'h0c, 32'h0000_0020);
      fire_src(5'h03);
      chk("illegal type vectors", vreq[3], 32'h0000_0001);
      pulse(1'b0);
      @(posedge clk_i);
      chk("illegal type not served", busy, 32'h0000_0000);
      finish_test();
   end
endmodule
